/* File: hdl/vc2tc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module vc2tc_persist #(
    parameter logic [2:0] N = vc2tc_pkg::DEF_PERSIST
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sample,
    input wire logic value,
    output logic defect
);
    typedef struct packed {
        logic [2:0] cnt;
        logic def;
    } vc2tc_persist_t;
    vc2tc_persist_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (sample) begin
            if (value == s_r.def) begin
                s_nxt.cnt = 3'h0;
            end else if (s_r.cnt == 3'(N - 3'h1)) begin
                s_nxt.def = value;
                s_nxt.cnt = 3'h0;
            end else begin
                s_nxt.cnt = 3'(s_r.cnt + 3'h1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign defect = s_r.def;
endmodule : vc2tc_persist

module vc2tc_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] dataIn,
    input wire logic dataValid,
    input wire logic frameStart,
    input wire logic n2Strobe,
    input wire logic incomingServerFail,
    input wire logic oneSecond,
    input wire logic [vc2tc_pkg::TRACE_W-1:0] expectedTrace,
    input wire logic mismatchDetectDisable,
    input wire logic serverFailReportEnable,
    input wire logic remoteDefectReportEnable,
    input wire logic outgoingDefectReportEnable,
    input wire logic [vc2tc_pkg::DEGRADE_INTERVAL_COUNT_W-1:0] degradeIntervalCount,
    input wire logic [vc2tc_pkg::ERR_W-1:0] degradeThreshold,
    input wire logic terminationPointMode,
    output logic [7:0] dataOut,
    output logic dataValidOut,
    output logic frameStartOut,
    output logic n2StrobeOut,
    output logic trailFailOut,
    output logic trailDegradeOut,
    output logic unequippedReport,
    output logic lossReport,
    output logic mismatchReport,
    output logic degradeReport,
    output logic serverFailReport,
    output logic remoteDefectReport,
    output logic outgoingDefectReport,
    output logic [vc2tc_pkg::TRACE_W-1:0] acceptedTrace,
    output logic [vc2tc_pkg::ERR_W-1:0] nearBlockErrSum,
    output logic [vc2tc_pkg::ERR_W-1:0] farBlockErrSum,
    output logic [vc2tc_pkg::ERR_W-1:0] outFarBlockErrSum,
    output logic nearDefectSec,
    output logic farDefectSec,
    output logic outFarDefectSec
);
    localparam int TW = vc2tc_pkg::TRACE_W;
    localparam int EW = vc2tc_pkg::ERR_W;

    typedef struct packed {
        logic [7:0] dOut;
        logic dValOut, fsOut, n2Out;
        logic bipArm, bipPrevOk;
        logic [1:0] bipAcc, bipPrev;
        logic [15:0] mfShift;
        logic [6:0] mfPos;
        logic inMf, fasErr;
        logic [TW-1:0] traceShift, traceCand, accepted;
        logic [1:0] traceCnt;
        logic acceptedOk, timDefect;
        logic [EW-1:0] secNear, secFar, secOut, pmNear, pmFar, pmOut;
        logic secNearDs, secFarDs, secOutDs, pmNearDs, pmFarDs, pmOutDs;
        logic [vc2tc_pkg::DEGRADE_INTERVAL_COUNT_W-1:0] degBad, degGood;
        logic degDefect, trailFail, trailDeg;
        logic rUneq, rLoss, rTim, rDeg, rSsf, rRdi, rOdi;
    } vc2tc_state_t;
    vc2tc_state_t s_r, s_nxt;

    function automatic logic [EW-1:0] satInc(input logic [EW-1:0] v, input logic inc);
        satInc = (inc && v != vc2tc_pkg::ERR_MAX) ? EW'(v + 12'h001) : v;
    endfunction : satInc

    logic n2Byte, nearErr, farErr, outErr, uneqDef, rdiDef, odiDef, mon;
    logic [15:0] shiftNew;
    logic [6:0] posNext;
    logic [1:0] bipByte;
    logic [TW-1:0] traceNew;
    logic [EW-1:0] nearNow;

    assign n2Byte = dataValid & n2Strobe;
    assign bipByte = {dataIn[7] ^ dataIn[5] ^ dataIn[3] ^ dataIn[1],
                      dataIn[6] ^ dataIn[4] ^ dataIn[2] ^ dataIn[0]};
    assign nearErr = n2Byte & s_r.bipPrevOk
        & (dataIn[vc2tc_pkg::N2_BIP_LSB +: 2] != s_r.bipPrev);
    assign farErr = n2Byte & dataIn[vc2tc_pkg::N2_REI];
    assign outErr = n2Byte & dataIn[vc2tc_pkg::N2_OEI];
    assign shiftNew = {s_r.mfShift[13:0], dataIn[1:0]};
    assign posNext = (s_r.mfPos == vc2tc_pkg::MF_LAST) ? 7'h00 : 7'(s_r.mfPos + 7'h01);
    assign traceNew = {s_r.traceShift[TW-3:0], dataIn[1:0]};
    assign nearNow = satInc(s_r.secNear, nearErr);
    assign mon = terminationPointMode == vc2tc_pkg::TERMINATION_POINT_MODE_MON;

    vc2tc_persist #(.N(vc2tc_pkg::DEF_PERSIST)) uUneq (
        .mclk(mclk), .rst_n(rst_n), .sample(n2Byte), .value(dataIn == 8'h00),
        .defect(uneqDef));
    vc2tc_persist #(.N(vc2tc_pkg::DEF_PERSIST)) uRdi (
        .mclk(mclk), .rst_n(rst_n),
        .sample(n2Byte & s_r.inMf & (posNext == vc2tc_pkg::RDI_POS)),
        .value(dataIn[vc2tc_pkg::N2_RDI]), .defect(rdiDef));
    vc2tc_persist #(.N(vc2tc_pkg::DEF_PERSIST)) uOdi (
        .mclk(mclk), .rst_n(rst_n),
        .sample(n2Byte & s_r.inMf & (posNext == vc2tc_pkg::ODI_POS)),
        .value(dataIn[vc2tc_pkg::N2_ODI]), .defect(odiDef));

    always_comb begin
        s_nxt = s_r;
        s_nxt.dOut = dataIn;
        s_nxt.dValOut = dataValid;
        s_nxt.fsOut = dataValid & frameStart;
        s_nxt.n2Out = n2Byte;
        if (dataValid && frameStart) begin
            s_nxt.bipPrev = s_r.bipAcc;
            s_nxt.bipPrevOk = s_r.bipArm;
            s_nxt.bipArm = 1'b1;
            s_nxt.bipAcc = bipByte;
        end else if (dataValid) begin
            s_nxt.bipAcc = s_r.bipAcc ^ bipByte;
        end
        if (n2Byte) begin
            s_nxt.mfShift = shiftNew;
            if (s_r.inMf) begin
                s_nxt.mfPos = posNext;
                if (posNext == vc2tc_pkg::FAS_END) begin
                    s_nxt.fasErr = shiftNew != vc2tc_pkg::MF_FAS;
                    if (s_nxt.fasErr && s_r.fasErr) begin
                        s_nxt.inMf = 1'b0;
                    end
                end
                if (posNext >= vc2tc_pkg::TTI_FIRST && posNext <= vc2tc_pkg::TTI_LAST) begin
                    s_nxt.traceShift = traceNew;
                end
                if (posNext == vc2tc_pkg::TTI_LAST) begin
                    if (traceNew == s_r.traceCand) begin
                        if (s_r.traceCnt == 2'(vc2tc_pkg::TRACE_PERSIST - 2'h1)) begin
                            s_nxt.accepted = traceNew;
                            s_nxt.acceptedOk = 1'b1;
                        end else begin
                            s_nxt.traceCnt = 2'(s_r.traceCnt + 2'h1);
                        end
                    end else begin
                        s_nxt.traceCand = traceNew;
                        s_nxt.traceCnt = 2'h1;
                    end
                end
            end else if (shiftNew == vc2tc_pkg::MF_FAS) begin
                s_nxt.inMf = 1'b1;
                s_nxt.fasErr = 1'b0;
                s_nxt.mfPos = vc2tc_pkg::FAS_END;
            end else begin
                s_nxt.mfPos = posNext;
            end
        end
        s_nxt.timDefect = s_r.acceptedOk & ~mismatchDetectDisable & ~incomingServerFail
            & (s_r.accepted != expectedTrace);
        if (oneSecond) begin
            s_nxt.pmNear = nearNow;
            s_nxt.pmFar = satInc(s_r.secFar, farErr);
            s_nxt.pmOut = satInc(s_r.secOut, outErr);
            s_nxt.pmNearDs = s_r.secNearDs | s_r.trailFail;
            s_nxt.pmFarDs = s_r.secFarDs | rdiDef;
            s_nxt.pmOutDs = s_r.secOutDs | odiDef;
            s_nxt.secNear = vc2tc_pkg::ERR_RST;
            s_nxt.secFar = vc2tc_pkg::ERR_RST;
            s_nxt.secOut = vc2tc_pkg::ERR_RST;
            {s_nxt.secNearDs, s_nxt.secFarDs, s_nxt.secOutDs} = 3'h0;
            if (nearNow > degradeThreshold) begin
                s_nxt.degGood = '0;
                if (4'(s_r.degBad + 4'h1) >= degradeIntervalCount) begin
                    s_nxt.degDefect = 1'b1;
                end else begin
                    s_nxt.degBad = 4'(s_r.degBad + 4'h1);
                end
            end else begin
                s_nxt.degBad = '0;
                if (4'(s_r.degGood + 4'h1) >= degradeIntervalCount) begin
                    s_nxt.degDefect = 1'b0;
                end else begin
                    s_nxt.degGood = 4'(s_r.degGood + 4'h1);
                end
            end
        end else begin
            s_nxt.secNear = nearNow;
            s_nxt.secFar = satInc(s_r.secFar, farErr);
            s_nxt.secOut = satInc(s_r.secOut, outErr);
            s_nxt.secNearDs = s_r.secNearDs | s_r.trailFail;
            s_nxt.secFarDs = s_r.secFarDs | rdiDef;
            s_nxt.secOutDs = s_r.secOutDs | odiDef;
        end
        s_nxt.trailFail = incomingServerFail | uneqDef | s_r.timDefect | ~s_r.inMf;
        s_nxt.trailDeg = s_r.degDefect;
        s_nxt.rUneq = mon & uneqDef;
        s_nxt.rLoss = mon & ~uneqDef & ~s_r.inMf;
        s_nxt.rTim = mon & ~uneqDef & s_r.inMf & s_r.timDefect;
        s_nxt.rDeg = mon & ~s_r.timDefect & s_r.inMf & s_r.degDefect;
        s_nxt.rSsf = mon & incomingServerFail & serverFailReportEnable;
        s_nxt.rRdi = mon & ~uneqDef & ~s_r.timDefect & s_r.inMf & rdiDef
            & remoteDefectReportEnable;
        s_nxt.rOdi = mon & ~uneqDef & ~s_r.timDefect & s_r.inMf & odiDef
            & outgoingDefectReportEnable;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dataOut = s_r.dOut;
    assign dataValidOut = s_r.dValOut;
    assign frameStartOut = s_r.fsOut;
    assign n2StrobeOut = s_r.n2Out;
    assign trailFailOut = s_r.trailFail;
    assign trailDegradeOut = s_r.trailDeg;
    assign unequippedReport = s_r.rUneq;
    assign lossReport = s_r.rLoss;
    assign mismatchReport = s_r.rTim;
    assign degradeReport = s_r.rDeg;
    assign serverFailReport = s_r.rSsf;
    assign remoteDefectReport = s_r.rRdi;
    assign outgoingDefectReport = s_r.rOdi;
    assign acceptedTrace = s_r.accepted;
    assign nearBlockErrSum = s_r.pmNear;
    assign farBlockErrSum = s_r.pmFar;
    assign outFarBlockErrSum = s_r.pmOut;
    assign nearDefectSec = s_r.pmNearDs;
    assign farDefectSec = s_r.pmFarDs;
    assign outFarDefectSec = s_r.pmOutDs;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_bip;
        nearErr && !oneSecond && s_r.secNear != vc2tc_pkg::ERR_MAX
            |=> s_r.secNear == 12'($past(s_r.secNear) + 12'h001);
    endproperty
    a_bip: assert property (p_bip) else $error("Parity error not counted.");
    property p_oom;
        s_r.inMf && s_r.fasErr && n2Byte && posNext == vc2tc_pkg::FAS_END
            && shiftNew != vc2tc_pkg::MF_FAS |=> !s_r.inMf;
    endproperty
    a_oom: assert property (p_oom) else $error("Alignment not lost.");
    property p_im;
        !s_r.inMf && n2Byte && shiftNew == vc2tc_pkg::MF_FAS
            |=> s_r.inMf && s_r.mfPos == vc2tc_pkg::FAS_END;
    endproperty
    a_im: assert property (p_im) else $error("Alignment not regained.");
    property p_ltc;
        !s_r.inMf |=> trailFailOut;
    endproperty
    a_ltc: assert property (p_ltc) else $error("Loss not in trail fail.");
    property p_ssf;
        incomingServerFail |=> !s_r.timDefect ##1 !mismatchReport;
    endproperty
    a_ssf: assert property (p_ssf) else $error("Mismatch during server fail.");
    property p_mismatch_detect_disable;
        mismatchDetectDisable [*2] |=> !mismatchReport;
    endproperty
    a_mismatch_detect_disable: assert property (p_mismatch_detect_disable) else $error("Mismatch while disabled.");
    property p_uneq;
        mon && uneqDef |=> unequippedReport && !lossReport && !mismatchReport;
    endproperty
    a_uneq: assert property (p_uneq) else $error("Unequipped masking wrong.");
    property p_uneqset;
        $rose(uneqDef) |-> $past(n2Byte && dataIn == 8'h00);
    endproperty
    a_uneqset: assert property (p_uneqset) else $error("Unequipped without zero byte.");
    property p_pass;
        dataValid |=> dataValidOut && dataOut == $past(dataIn);
    endproperty
    a_pass: assert property (p_pass) else $error("Passing data altered.");
    property p_deg;
        ##1 trailDegradeOut == $past(s_r.degDefect);
    endproperty
    a_deg: assert property (p_deg) else $error("Trail degrade mismatch.");
    property p_rdi;
        !remoteDefectReportEnable |=> !remoteDefectReport;
    endproperty
    a_rdi: assert property (p_rdi) else $error("Remote defect reported while off.");
    c_align: cover property (!s_r.inMf ##1 s_r.inMf);
    c_uneq: cover property ($rose(uneqDef));
    c_accept: cover property ($rose(s_r.acceptedOk));
    c_deg: cover property ($rose(s_r.degDefect));
endmodule : vc2tc_monitor

`default_nettype wire

/* File: hdl/vc2tc_pkg.sv */
package vc2tc_pkg;
    localparam int TRACE_W = 128;
    localparam int ERR_W = 12;
    localparam int DEGRADE_INTERVAL_COUNT_W = 4;
    // N2 bit 1 is the byte's MSB; bits 1-2 carry the parity.
    localparam int N2_BIP_LSB = 6;
    localparam int N2_REI = 3;
    localparam int N2_OEI = 2;
    localparam int N2_ODI = 1;
    localparam int N2_RDI = 0;
    localparam logic [15:0] MF_FAS = 16'hFFFE;
    localparam logic [6:0] MF_LAST = 7'h4B;
    localparam logic [6:0] FAS_END = 7'h07;
    localparam logic [6:0] TTI_FIRST = 7'h08;
    localparam logic [6:0] TTI_LAST = 7'h47;
    localparam logic [6:0] RDI_POS = 7'h48;
    localparam logic [6:0] ODI_POS = 7'h49;
    localparam logic [2:0] DEF_PERSIST = 3'h5;
    localparam logic [1:0] TRACE_PERSIST = 2'h3;
    localparam logic TERMINATION_POINT_MODE_MON = 1'b1;
    localparam logic [ERR_W-1:0] ERR_MAX = 12'hFFF;
    localparam logic [ERR_W-1:0] ERR_RST = 12'h000;
    localparam logic [6:0] MF_POS_RST = 7'h00;
    localparam logic [1:0] BIP_RST = 2'h0;
endpackage : vc2tc_pkg

/* File: tb/vc2tc_source_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Connection-side byte source: frames with an overhead byte at byte 1.
module vc2tc_source_model #(
    parameter int FLEN = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic bipErr,
    input wire logic rei,
    input wire logic oei,
    input wire logic rdi,
    input wire logic odi,
    input wire logic fasErr,
    input wire logic zeroN2,
    input wire logic [127:0] trace,
    output logic [7:0] dataIn,
    output logic dataValid,
    output logic frameStart,
    output logic n2Strobe
);
    int seed = 39077;
    int pos = 0;
    int mf = 0;
    logic [1:0] bip = 2'h0;
    logic [1:0] bipPrev = 2'h0;
    logic [1:0] pr;
    logic [7:0] b;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {dataIn, dataValid, frameStart, n2Strobe} <= 11'h000;
        end else if (($random(seed) & 3) == 0) begin
            // Idle cycles scramble the lane so stale values never look valid.
            dataValid <= 1'b0;
            dataIn <= ~dataIn;
            {frameStart, n2Strobe} <= 2'($random(seed));
        end else begin
            b = 8'($random(seed));
            if (pos == 0) begin
                bipPrev = bip;
                bip = 2'h0;
            end
            if (pos == 1) begin
                if (mf < 7) pr = 2'h3 ^ {1'b0, fasErr};
                else if (mf == 7) pr = 2'h2 ^ {1'b0, fasErr};
                else if (mf < 72) pr = trace[143 - 2 * mf -: 2];
                else if (mf == 72) pr = {1'b0, rdi};
                else if (mf == 73) pr = {odi, 1'b0};
                else pr = 2'h0;
                b = {bipPrev ^ {2{bipErr}}, 1'b1, b[4], rei, oei, pr};
                if (zeroN2) b = 8'h00;
            end
            bip ^= b[7:6] ^ b[5:4] ^ b[3:2] ^ b[1:0];
            dataIn <= b;
            dataValid <= 1'b1;
            frameStart <= (pos == 0);
            n2Strobe <= (pos == 1);
            pos = (pos + 1) % FLEN;
            if (pos == 0) mf = (mf + 1) % 76;
        end
    end
endmodule : vc2tc_source_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int MF = 900;
    localparam int SEC = 5000;
    localparam int TF = 0, LS = 1, UQ = 2, MM = 3, DG = 4, SF = 5, RD = 6, OD = 7;
    localparam int TD = 8, NS = 9, FS = 10, OS = 11;
    localparam logic [127:0] TRACE_A = 128'h0123456789ABCDEF0123456789ABCDEF;
    localparam logic [127:0] TRACE_B = 128'hFEDCBA9876543210FEDCBA9876543210;
    logic mclk = 1'b0, rst_n = 1'b0, oneSecond = 1'b0, incomingServerFail = 1'b0;
    logic mismatchDetectDisable = 1'b0, serverFailReportEnable = 1'b1;
    logic remoteDefectReportEnable = 1'b1, outgoingDefectReportEnable = 1'b1;
    logic terminationPointMode = 1'b1;
    logic bipErr = 1'b0, rei = 1'b0, oei = 1'b0, rdi = 1'b0, odi = 1'b0;
    logic fasErr = 1'b0, zeroN2 = 1'b0;
    logic [vc2tc_pkg::DEGRADE_INTERVAL_COUNT_W-1:0] degradeIntervalCount = 4'h1;
    logic [vc2tc_pkg::ERR_W-1:0] degradeThreshold = 12'h00A;
    logic [127:0] expectedTrace = TRACE_A, trace = TRACE_A, acceptedTrace;
    logic [7:0] dataIn, dataOut;
    logic dataValid, frameStart, n2Strobe, dataValidOut, frameStartOut, n2StrobeOut;
    logic trailFailOut, trailDegradeOut, unequippedReport, lossReport, mismatchReport;
    logic degradeReport, serverFailReport, remoteDefectReport, outgoingDefectReport;
    logic [vc2tc_pkg::ERR_W-1:0] nearBlockErrSum, farBlockErrSum, outFarBlockErrSum;
    logic nearDefectSec, farDefectSec, outFarDefectSec;
    logic [10:0] expQ[$];
    int secCount = 0, lastCount = 0, nMismatch = 0, nCompared = 0, i;
    wire logic [11:0] flags = {outFarDefectSec, farDefectSec, nearDefectSec, trailDegradeOut,
        outgoingDefectReport, remoteDefectReport, serverFailReport, degradeReport,
        mismatchReport, unequippedReport, lossReport, trailFailOut};

    vc2tc_source_model i_vc2tc_source_model (.*);
    vc2tc_monitor i_vc2tc_monitor (.*);

    initial begin
        forever #2 mclk = ~mclk;
    end
    initial begin
        forever begin
            repeat (SEC - 1) @(posedge mclk);
            oneSecond <= 1'b1;
            @(posedge mclk);
            oneSecond <= 1'b0;
        end
    end

    task automatic conclude;
        $display("compared %0d, mismatched %0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    task automatic cmpVal(input logic [127:0] got, input logic [127:0] exp);
        nCompared++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : cmpVal
    task automatic cmpFlag(input logic got, input logic exp);
        nCompared++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: flag %h, expected %h", $time, got, exp);
        end
    endtask : cmpFlag
    task automatic waitFlag(input int idx, input logic val, input int bound);
        int k;
        for (k = 0; k < bound && flags[idx] !== val; k++) begin
            @(posedge mclk);
            #1;
        end
        cmpFlag(flags[idx], val);
        if (k == bound) conclude();
    endtask : waitFlag
    task automatic waitTick;
        int k;
        for (k = 0; k < SEC + 10 && oneSecond !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
        if (k == SEC + 10) begin
            nMismatch++;
            $display("unexpected at %0t: no tick, got %h, expected %h", $time, 1'b0, 1'b1);
            conclude();
        end
        repeat (4) @(posedge mclk);
        #1;
    endtask : waitTick

    // Notes each byte taken and counts overhead bytes per second.
    always @(posedge mclk) begin
        if (dataValid) expQ.push_back({frameStart, n2Strobe, dataIn});
        // An overhead byte taken on the tick edge still belongs to the closing second.
        if (dataValid && n2Strobe) secCount++;
        if (oneSecond) begin
            lastCount = secCount;
            secCount = 0;
        end
    end
    always @(posedge mclk) begin
        if (dataValidOut) cmpVal({frameStartOut, n2StrobeOut, dataOut}, expQ.pop_front());
    end
    initial begin
        repeat (95000) @(posedge mclk);
        nMismatch++;
        $display("unexpected at %0t: run limit, got %h, expected %h", $time, 1'b0, 1'b1);
        conclude();
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        cmpFlag(flags[TF], 1'b1);
        cmpFlag(flags[LS], 1'b1);
        waitFlag(LS, 1'b0, 3 * MF);
        cmpFlag(flags[TF], 1'b0);
        for (i = 0; i < 5 * MF && acceptedTrace !== TRACE_A; i++) begin
            @(posedge mclk);
            #1;
        end
        cmpVal(acceptedTrace, TRACE_A);
        if (i == 5 * MF) conclude();
        cmpFlag(flags[MM], 1'b0);
        $display("alignment and trace test done");
        @(posedge mclk);
        expectedTrace <= TRACE_B;
        waitFlag(MM, 1'b1, 10);
        cmpFlag(flags[TF], 1'b1);
        @(posedge mclk);
        incomingServerFail <= 1'b1;
        waitFlag(MM, 1'b0, 10);
        cmpFlag(flags[SF], 1'b1);
        cmpFlag(flags[TF], 1'b1);
        @(posedge mclk);
        serverFailReportEnable <= 1'b0;
        waitFlag(SF, 1'b0, 10);
        @(posedge mclk);
        {incomingServerFail, serverFailReportEnable} <= 2'h1;
        waitFlag(MM, 1'b1, 10);
        @(posedge mclk);
        mismatchDetectDisable <= 1'b1;
        waitFlag(MM, 1'b0, 10);
        @(posedge mclk);
        {mismatchDetectDisable, expectedTrace} <= {1'b0, TRACE_A};
        waitFlag(TF, 1'b0, 10);
        $display("mismatch test done");
        @(posedge mclk);
        {bipErr, rei, oei} <= 3'h7;
        waitTick();
        waitTick();
        cmpVal(128'(nearBlockErrSum), 128'(lastCount));
        cmpVal(128'(farBlockErrSum), 128'(lastCount));
        cmpVal(128'(outFarBlockErrSum), 128'(lastCount));
        cmpFlag(flags[DG], 1'b1);
        cmpFlag(flags[TD], 1'b1);
        cmpFlag(flags[NS], 1'b0);
        @(posedge mclk);
        {bipErr, rei, oei} <= 3'h0;
        waitTick();
        waitTick();
        cmpVal(128'(nearBlockErrSum), 128'h0);
        cmpFlag(flags[DG], 1'b0);
        $display("error count test done");
        @(posedge mclk);
        {rdi, odi} <= 2'h3;
        waitFlag(RD, 1'b1, 7 * MF);
        waitFlag(OD, 1'b1, MF);
        waitTick();
        cmpFlag(flags[FS], 1'b1);
        cmpFlag(flags[OS], 1'b1);
        @(posedge mclk);
        remoteDefectReportEnable <= 1'b0;
        waitFlag(RD, 1'b0, 10);
        cmpFlag(flags[OD], 1'b1);
        @(posedge mclk);
        {remoteDefectReportEnable, rdi, odi} <= 3'h4;
        waitFlag(OD, 1'b0, 7 * MF);
        cmpFlag(flags[RD], 1'b0);
        $display("remote defect test done");
        @(posedge mclk);
        fasErr <= 1'b1;
        waitFlag(LS, 1'b1, 4 * MF);
        cmpFlag(flags[TF], 1'b1);
        waitTick();
        cmpFlag(flags[NS], 1'b1);
        @(posedge mclk);
        fasErr <= 1'b0;
        waitFlag(LS, 1'b0, 3 * MF);
        $display("loss test done");
        @(posedge mclk);
        zeroN2 <= 1'b1;
        waitFlag(UQ, 1'b1, 100);
        repeat (4 * MF) @(posedge mclk);
        #1;
        cmpFlag(flags[LS], 1'b0);
        cmpFlag(flags[TF], 1'b1);
        @(posedge mclk);
        terminationPointMode <= 1'b0;
        waitFlag(UQ, 1'b0, 10);
        @(posedge mclk);
        {terminationPointMode, zeroN2} <= 2'h2;
        waitFlag(LS, 1'b1, 200);
        cmpFlag(flags[UQ], 1'b0);
        waitFlag(LS, 1'b0, 3 * MF);
        $display("unequipped test done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
